// File: core/sdac_core.v
// serial converter input control, top level
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "sdac_regs.vh"
module sdac_core (
   // clock and reset
   input wire clk_sys_in,
   input wire rstn_in,
   // serial link from host
   input wire sync_n_in,
   input wire sclk_in,
   input wire din_in,
   // converter side
   output reg [7:0] code_out,
   output reg [1:0] mode_out,
   output reg power_down_out,
   output reg update_out,
   // wishbone
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [3:0] wb_adr_in,
   input wire [31:0] wb_dat_in,
   input wire [3:0] wb_sel_in,
   output wire [31:0] wb_dat_out,
   output wire wb_ack_out
);
   // ------------------------------------------
   // pin synchronisers
   // ------------------------------------------
   wire sync_n_s;
   wire sclk_s;
   wire din_s;
   reg sync_n_d;
   reg sclk_d;
   reg din_d;
   reg [15:0] shift;
   reg [4:0] count;
   reg busy;
   reg [7:0] frames;
   wire enable;
   wire [15:0] word;
   genvar gi;
   wire [2:0] raw_pins;
   wire [2:0] sync_pins;
   // frame select synchronised inverted so the reset level matches its idle level
   assign raw_pins = {~sync_n_in, sclk_in, din_in};
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         sdac_sync u_sync (
            .clk_sys_in(clk_sys_in),
            .rstn_in(rstn_in),
            .d_in(raw_pins[gi]),
            .q_out(sync_pins[gi])
         );
      end
   endgenerate
   assign sync_n_s = ~sync_pins[2];
   assign sclk_s = sync_pins[1];
   assign din_s = sync_pins[0];
   // ------------------------------------------
   // edge detection
   // ------------------------------------------
   // data delayed one cycle so it matches the delayed clock edge
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync_n_d <= 1'b1;
         sclk_d <= 1'b0;
         din_d <= 1'b0;
      end else begin
         sync_n_d <= sync_n_s;
         sclk_d <= sclk_s;
         din_d <= din_s;
      end
   end
   wire frame_start;
   wire frame_abort;
   wire sclk_fall;
   assign frame_start = sync_n_d & ~sync_n_s;
   assign frame_abort = ~sync_n_d & sync_n_s;
   assign sclk_fall = sclk_d & ~sclk_s & ~sync_n_s & busy;
   assign word = {shift[14:0], din_d};
   // ------------------------------------------
   // shift register and apply
   // ------------------------------------------
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         shift <= 16'h0000;
         count <= 5'h00;
         busy <= 1'b0;
         frames <= 8'h00;
         code_out <= `SDAC_CODE_RST;
         mode_out <= `SDAC_MODE_RST;
         power_down_out <= 1'b0;
         update_out <= 1'b0;
      end else begin
         update_out <= 1'b0;
         if (frame_start) begin
            shift <= 16'h0000;
            count <= 5'h00;
            busy <= enable;
         end else if (frame_abort) begin
            shift <= 16'h0000;
            count <= 5'h00;
            busy <= 1'b0;
         end else if (sclk_fall) begin
            shift <= word;
            count <= count + 5'h01;
            if (count == `SDAC_LAST_BIT) begin
               busy <= 1'b0;
               // bits 15:14 ignored, code loaded from bits 11:4 in every mode
               mode_out <= {word[`SDAC_MODE_HI], word[`SDAC_MODE_LO]};
               power_down_out <= (word[`SDAC_MODE_HI:`SDAC_MODE_LO] != `SDAC_MODE_NORMAL);
               code_out <= word[`SDAC_CODE_HI:`SDAC_CODE_LO];
               update_out <= 1'b1;
               frames <= frames + 8'h01;
            end
         end
      end
   end
   // ------------------------------------------
   // register window
   // ------------------------------------------
   sdac_wb u_wb (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .wb_cyc_in(wb_cyc_in),
      .wb_stb_in(wb_stb_in),
      .wb_we_in(wb_we_in),
      .wb_adr_in(wb_adr_in),
      .wb_dat_in(wb_dat_in),
      .wb_sel_in(wb_sel_in),
      .wb_dat_out(wb_dat_out),
      .wb_ack_out(wb_ack_out),
      .code_in(code_out),
      .mode_in(mode_out),
      .count_in(count),
      .busy_in(busy),
      .frames_in(frames),
      .enable_out(enable)
   );
endmodule // sdac_core

// File: pkg/sdac_regs.vh
// constants of the serial converter front end
// Contract
// - falling frame select starts a write
// - sample data on falling serial clock edges
// - sixteenth falling edge applies the word
// - new frame needs frame select high again
// - early frame select rise discards the frame
// - first two bits ignored, next two mode
// - mode bits 13:12 select normal or power-down
// - code is straight binary 0 to 255
// - converter register clears to zero at reset
// - power-down keeps converter register contents (here code_out is still loaded from the word in power-down)
`ifndef SDAC_REGS_VH
`define SDAC_REGS_VH
`define SDAC_WORD_BITS 16
`define SDAC_CNT_W 5
`define SDAC_LAST_BIT 5'h0F
`define SDAC_MODE_HI 13
`define SDAC_MODE_LO 12
`define SDAC_CODE_HI 11
`define SDAC_CODE_LO 4
`define SDAC_MODE_NORMAL 2'h0
`define SDAC_MODE_PD_1K 2'h1
`define SDAC_MODE_PD_100K 2'h2
`define SDAC_MODE_PD_HIZ 2'h3
`define SDAC_CODE_RST 8'h00
`define SDAC_MODE_RST 2'h0
`define SDAC_ADR_CODE 4'h0
`define SDAC_ADR_MODE 4'h4
`define SDAC_ADR_STAT 4'h8
`define SDAC_ADR_CTRL 4'hC
`endif

// File: core/sdac_sync.v
// two flip-flop synchroniser for one level
`timescale 1ns/1ns
module sdac_sync (
   // clock and reset
   input wire clk_sys_in,
   input wire rstn_in,
   // level
   input wire d_in,
   output reg q_out
);
   reg meta;
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule // sdac_sync

// File: core/sdac_wb.v
// wishbone classic slave register window
`timescale 1ns/1ns
`include "sdac_regs.vh"
module sdac_wb (
   // clock and reset
   input wire clk_sys_in,
   input wire rstn_in,
   // wishbone
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [3:0] wb_adr_in,
   input wire [31:0] wb_dat_in,
   input wire [3:0] wb_sel_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   // block state
   input wire [7:0] code_in,
   input wire [1:0] mode_in,
   input wire [4:0] count_in,
   input wire busy_in,
   input wire [7:0] frames_in,
   output reg enable_out
);
   reg [31:0] next_dat;
   always @* begin
      case (wb_adr_in)
         `SDAC_ADR_CODE: next_dat = {24'h000000, code_in};
         `SDAC_ADR_MODE: next_dat = {30'h00000000, mode_in};
         `SDAC_ADR_STAT: next_dat = {16'h0000, frames_in, 2'h0, busy_in, count_in};
         `SDAC_ADR_CTRL: next_dat = {31'h00000000, enable_out};
         default: next_dat = 32'h00000000;
      endcase
   end
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
         enable_out <= 1'b1;
      end else begin
         wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
         wb_dat_out <= next_dat;
         // write lands at the edge where the master sees ack high
         if (wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in &&
             wb_sel_in[0] && wb_adr_in == `SDAC_ADR_CTRL) begin
            enable_out <= wb_dat_in[0];
         end
      end
   end
endmodule // sdac_wb

// File: test/sdac_core_properties.sv
// assertions on the converter front end ports
`timescale 1ns/1ns
module sdac_core_properties (
   input wire clk_sys_in, rstn_in, sclk_in, power_down_out, update_out,
   input wire wb_cyc_in, wb_stb_in, wb_ack_out,
   input wire [7:0] code_out,
   input wire [1:0] mode_out
);
   logic [3:0] gap;
   always @(posedge clk_sys_in or negedge rstn_in)
      if (!rstn_in) gap <= 4'hF;
      else gap <= $fell(sclk_in) ? 4'h0 : gap + 4'(gap != 4'hF);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   chk_pd_mode: assert property (power_down_out == |mode_out) else $error("pd");
   chk_code_hold: assert property (!$stable(code_out) |-> update_out) else $error("code");
   chk_mode_hold: assert property (!$stable(mode_out) |-> update_out) else $error("mode");
   chk_upd_pulse: assert property (update_out |=> !update_out) else $error("upd");
   chk_upd_prompt: assert property (update_out |-> gap < 4'hA) else $error("late");
   chk_reset_zero: assert property ($rose(rstn_in) |-> code_out == 8'h00) else $error("rst");
   chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack");
   chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("wb");
   cover property (update_out && mode_out == 2'h3);
   cover property (update_out && code_out == 8'hFF);
   cover property (wb_ack_out);
endmodule // sdac_core_properties
bind sdac_core sdac_core_properties sdac_core_properties_i (.*);

// File: test/sdac_host.sv
// host model driving the three wire link
`timescale 1ns/1ns
module sdac_host (
   input wire clk_sys_in,
   output logic sync_n_out = 1'h1, sclk_out = 1'h0, din_out = 1'h0
);
   task send(input [15:0] w, input int n);
      @(posedge clk_sys_in) sync_n_out <= 1'h0;
      for (int i = 15; i > 15 - n; i--) begin
         @(posedge clk_sys_in) din_out <= w[i];
         sclk_out <= 1'h1;
         repeat (4) @(posedge clk_sys_in);
         sclk_out <= 1'h0;
         repeat (3) @(posedge clk_sys_in);
      end
      repeat (6) @(posedge clk_sys_in);
      sync_n_out <= 1'h1;
      din_out <= 1'h0;
      repeat (6) @(posedge clk_sys_in);
   endtask
endmodule // sdac_host

// File: test/sdac_core_tb.sv
// bench of the converter front end
`timescale 1ns/1ns
module sdac_core_tb;
   logic clk_sys_in = 1'h0, rstn_in = 1'h0, wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0;
   logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'hF;
   logic [31:0] wb_dat_in = 32'h0, q, wb_dat_out;
   logic [7:0] code_out;
   logic [1:0] mode_out;
   logic sync_n_in, sclk_in, din_in, wb_ack_out, power_down_out, update_out;
   int num_errors = 0, num_checks = 0, upd_cnt = 0;
   always @(posedge clk_sys_in) if (update_out === 1'h1) upd_cnt++;
   always #10 clk_sys_in = ~clk_sys_in;
   sdac_core sdac_core_i (.*);
   sdac_host sdac_host_i (.clk_sys_in, .sync_n_out(sync_n_in), .sclk_out(sclk_in), .din_out(din_in));
   task check(input [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wb(input [3:0] a, input w, input [31:0] d);
      @(posedge clk_sys_in);
      {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, w, a, d};
      @(posedge clk_sys_in);
      while (wb_ack_out !== 1'h1) @(posedge clk_sys_in);
      q = wb_dat_out;
      {wb_cyc_in, wb_stb_in} <= 2'h0;
   endtask
   task outs(input [7:0] c, input [1:0] md);
      check(code_out, c);
      check(mode_out, md);
      check(power_down_out, md != 2'h0);
      wb(4'h0, 1'h0, 32'h0);
      check(q, c);
   endtask
   task conclude;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      conclude;
   end
   initial begin
      repeat (6) @(posedge clk_sys_in);
      rstn_in <= 1'h1;
      repeat (3) @(posedge clk_sys_in);
      outs(8'h00, 2'h0);
      wb(4'h2, 1'h0, 32'h0);
      check(q, 32'h0);
      for (int m = 0; m < 4; m++) begin
         sdac_host_i.send({2'h3, 2'(m), 8'hFF - 8'(m), 4'hF}, 16);
         outs(8'hFF - 8'(m), 2'(m));
      end
      sdac_host_i.send(16'h0000, 16);
      outs(8'h00, 2'h0);
      wb(4'h8, 1'h0, 32'h0);
      check(q, 32'h00000500);
      $display("modes done");
      sdac_host_i.send(16'h3FF0, 15);
      outs(8'h00, 2'h0);
      sdac_host_i.send(16'h0120, 16);
      outs(8'h12, 2'h0);
      $display("abort done");
      wb(4'hC, 1'h1, 32'h0);
      wb(4'hC, 1'h0, 32'h0);
      check(q, 32'h0);
      sdac_host_i.send(16'h0340, 16);
      outs(8'h12, 2'h0);
      wb(4'hC, 1'h1, 32'h1);
      check(upd_cnt, 32'd6);
      $display("control done");
      @(posedge clk_sys_in) rstn_in <= 1'h0;
      repeat (2) @(posedge clk_sys_in);
      rstn_in <= 1'h1;
      repeat (3) @(posedge clk_sys_in);
      outs(8'h00, 2'h0);
      wb(4'hC, 1'h0, 32'h0);
      check(q, 32'h1);
      sdac_host_i.send(16'h0560, 16);
      outs(8'h56, 2'h0);
      $display("reset done");
      conclude;
   end
endmodule // sdac_core_tb
